// [hw/aglc_pkg.sv]
package aglc_pkg;

    // ==========================================================
    // Timing
    localparam int unsigned CLK_MHZ = 100;
    localparam int unsigned ATTACK_US = 32;
    localparam int unsigned RELEASE_MS = 250;
    // One divider tick per microsecond
    localparam int unsigned TICK_CYC = CLK_MHZ;
    localparam int unsigned ATTACK_TICKS = ATTACK_US;
    localparam int unsigned RELEASE_TICKS_DFLT = RELEASE_MS * 1000;
    localparam int unsigned ATTACK_CYC = ATTACK_US * CLK_MHZ;

    // ==========================================================
    // Volume
    localparam int unsigned STEP_W = 6;
    localparam logic [5:0] STEP_MAX = 6'h3f;

    // ==========================================================
    // Register map (byte addresses)
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATE = 8'h04;
    localparam logic [7:0] ADDR_GAIN = 8'h08;
    localparam logic [7:0] ADDR_INT_STAT = 8'h0c;
    localparam logic [7:0] ADDR_INT_MASK = 8'h10;

    // Control fields
    localparam int unsigned CTRL_LIMIT_BIT = 0;
    localparam int unsigned CTRL_CLIP_BIT = 1;
    localparam logic [1:0] CTRL_RESET = 2'h3;

    // State fields
    localparam int unsigned ST_VOL_LSB = 0;
    localparam int unsigned ST_APPLIED_LSB = 8;
    localparam int unsigned ST_OUT_EN_BIT = 16;
    localparam int unsigned ST_FAULT_LSB = 17;
    localparam int unsigned ST_REDUCING_BIT = 20;

    // Interrupt fields
    localparam int unsigned INT_W = 5;
    localparam logic [4:0] INT_MASK_RESET = 5'h00;

    // Pulled-up pins rest high, all else low
    localparam logic [15:0] SYNC_RESET = 16'h0300;

    typedef struct packed {
        logic over_temp;
        logic short_out;
        logic supply_low;
    } aglc_fault_s;

    typedef struct packed {
        logic fault_otp;
        logic fault_short;
        logic fault_supply;
        logic gain_up;
        logic gain_down;
    } aglc_event_s;

    // Gain of a volume step in tenths of a dB
    function automatic logic signed [11:0] step_gain(input logic [5:0] s);
        logic signed [11:0] g;
        g = 12'sh000;
        if (s == 6'h00) begin
            g = -12'sd750;
        end else if (s <= 6'h06) begin
            g = 12'(-400 + 60 * (int'(s) - 1));
        end else if (s <= 6'h0a) begin
            g = 12'(-75 + 25 * (int'(s) - 7));
        end else if (s == 6'h0b) begin
            g = 12'sd15;
        end else if (s == 6'h0c) begin
            g = 12'sd30;
        end else begin
            g = 12'(40 + 4 * (int'(s) - 13));
        end
        return g;
    endfunction

endpackage

// [hw/aglc_limiter.sv]
`timescale 1ns/10ps
module aglc_limiter #(
    parameter int unsigned RELEASE_TICKS = aglc_pkg::RELEASE_TICKS_DFLT
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Control
    input wire logic run,
    input wire logic limit_en,
    input wire logic anticlip_en,
    input wire logic [5:0] volume,
    // Detectors
    input wire logic peak_over,
    input wire logic clip_seen,
    input wire logic ideal_below,
    // Result
    output logic [5:0] reduction,
    output logic gain_down,
    output logic gain_up
);
    localparam int unsigned TW = $clog2(aglc_pkg::TICK_CYC);
    localparam int unsigned RW = $clog2(RELEASE_TICKS + 1);
    localparam int unsigned AW = $clog2(aglc_pkg::ATTACK_TICKS + 1);

    logic [TW-1:0] div;
    logic tick;
    logic [AW-1:0] atk_cnt;
    logic [RW-1:0] rel_cnt;
    logic over;
    logic want_down;
    logic want_up;
    logic step;

    // ==========================================================
    // Decision
    assign over = (limit_en & peak_over) | (anticlip_en & clip_seen);
    // Steps never go below step 0, the full 75 dB span
    assign want_down = run && over && (reduction < volume) && // [R6] [R18]
        (atk_cnt == '0); // [R2] [R4] [R7]
    assign want_up = run && !over && ideal_below && (reduction != '0) &&
        (rel_cnt == '0); // [R5]
    assign step = want_down | want_up;

    // ==========================================================
    // Microsecond divider, restarted by each step so spacing is exact
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div <= '0;
        end else if (step || div == TW'(aglc_pkg::TICK_CYC - 1)) begin
            div <= '0;
        end else begin
            div <= div + 1'b1;
        end
    end
    assign tick = (div == TW'(aglc_pkg::TICK_CYC - 1)) && !step;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            atk_cnt <= '0;
        end else if (want_down) begin
            atk_cnt <= AW'(aglc_pkg::ATTACK_TICKS); // [R3]
        end else if (tick && atk_cnt != '0) begin
            atk_cnt <= atk_cnt - 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rel_cnt <= '0;
        end else if (want_down) begin
            rel_cnt <= '0; // [R5]
        end else if (want_up) begin
            rel_cnt <= RW'(RELEASE_TICKS); // [R5] [R7]
        end else if (tick && rel_cnt != '0) begin
            rel_cnt <= rel_cnt - 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            reduction <= '0;
            gain_down <= 1'b0;
            gain_up <= 1'b0;
        end else begin
            gain_down <= want_down;
            gain_up <= want_up;
            if (want_down) begin
                reduction <= reduction + 1'b1; // [R2]
            end else if (want_up) begin
                reduction <= reduction - 1'b1; // [R5]
            end
        end
    end

    // ==========================================================
    // Checks
    logic [12:0] since_down;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            since_down <= '1;
        end else if (gain_down) begin
            since_down <= '0;
        end else if (since_down != '1) begin
            since_down <= since_down + 1'b1;
        end
    end

    property p_attack_gap;
        @(posedge hclk) disable iff (!hresetn)
        gain_down |-> since_down >= 13'(aglc_pkg::ATTACK_CYC - 1);
    endproperty
    a_attack_gap: assert property (p_attack_gap) // [R3]
        else $error("gain decrements closer than attack time");

    property p_down_cause;
        @(posedge hclk) disable iff (!hresetn)
        gain_down |-> $past(over) && $past(run);
    endproperty
    a_down_cause: assert property (p_down_cause) // [R4]
        else $error("gain stepped down without overload");

    sequence s_step_up;
        gain_up ##1 !gain_down [*2];
    endsequence
    property p_up_spaced;
        @(posedge hclk) disable iff (!hresetn)
        s_step_up |-> !gain_up;
    endproperty
    a_up_spaced: assert property (p_up_spaced) // [R5]
        else $error("gain increments too close together");

endmodule

// [hw/aglc_top.sv]
// Our own choices: the register offsets and the AHB-Lite register port.
`timescale 1ns/10ps
// How it works
// [R1] Six-bit volume step maps to gain, -75 dB up to 24.0 dB.
// [R2] While peak exceeds threshold, lower gain by one step.
// [R3] Each decrement restarts attack timer; decrements at least 32 us apart.
// [R4] Keep stepping down until peak no longer exceeds threshold.
// [R5] Step back up when ideal level drops; first at once, then 250 ms apart.
// [R6] Limiter and anti-clip together may reduce gain across 75 dB.
// [R7] Clipping seen in duty cycle lowers gain; 250 ms release per step.
// [R8] Low silence input disables outputs immediately, high enables.
// [R9] Silence input rests high when left unconnected.
// [R10] Low power-down input turns off amplifier and its bias.
// [R11] Power-down input rests high when left unconnected.
// [R12] Outputs off at 1.8 V or below, back on at 2.0 V.
// [R13] Output short disables outputs; they return once short clears.
// [R14] Above 150 C outputs off, unlatched; resume after 30 C drop.
// [R15] Host should assert silence before switching the supply.
// [R16] Volume step arrives as a six-bit code sampled on hclk.
// [R17] Outputs on only when not silenced, not powered down, no fault.
// [R18] Applied gain never exceeds the gain chosen by the volume step.
module aglc_top #(
    parameter int unsigned RELEASE_TICKS = aglc_pkg::RELEASE_TICKS_DFLT
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Host pins
    input wire logic silence_n,
    input wire logic power_down_n,
    input wire logic [5:0] volume_code,
    // Analog detectors
    input wire logic peak_over,
    input wire logic ideal_below,
    input wire logic clip_seen,
    input wire logic vdd_le_1v8,
    input wire logic vdd_ge_2v0,
    input wire logic temp_hot,
    input wire logic temp_cooled,
    input wire logic short_seen,
    // Amplifier control
    output logic out_en,
    output logic bias_en,
    output logic [5:0] gain_step,
    output logic irq
);
    // ==========================================================
    // Pin synchronisers
    logic [15:0] pins;
    logic [15:0] sync1;
    logic [15:0] sync2;
    logic [15:0] sync3;
    logic [15:0] pin_q;

    assign pins = {volume_code, power_down_n, silence_n, peak_over,
        ideal_below, clip_seen, vdd_le_1v8, vdd_ge_2v0, temp_hot,
        temp_cooled, short_seen};

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sync1 <= aglc_pkg::SYNC_RESET; // [R9] [R11]
            sync2 <= aglc_pkg::SYNC_RESET;
            sync3 <= aglc_pkg::SYNC_RESET;
            pin_q <= aglc_pkg::SYNC_RESET;
        end else begin
            sync1 <= pins;
            sync2 <= sync1;
            sync3 <= sync2;
            // A bit moves only once the last two stages agree
            pin_q <= (sync2 & sync3) | (pin_q & (sync2 | sync3)); // [R16]
        end
    end

    logic [5:0] vol_q;
    logic pdn_q;
    logic sil_q;
    logic peak_q;
    logic ideal_q;
    logic clip_q;
    logic low_q;
    logic ok_q;
    logic hot_q;
    logic cool_q;
    logic short_q;
    assign {vol_q, pdn_q, sil_q, peak_q, ideal_q, clip_q, low_q, ok_q,
        hot_q, cool_q, short_q} = pin_q;

    // ==========================================================
    // Faults, none of them latched
    aglc_pkg::aglc_fault_s fault;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fault <= '{over_temp: 1'b0, short_out: 1'b0, supply_low: 1'b1};
        end else begin
            // Hysteresis: the low trip wins over the recovery level
            if (low_q) begin
                fault.supply_low <= 1'b1; // [R12]
            end else if (ok_q) begin
                fault.supply_low <= 1'b0; // [R12]
            end
            if (hot_q) begin
                fault.over_temp <= 1'b1; // [R14]
            end else if (cool_q) begin
                fault.over_temp <= 1'b0; // [R14]
            end
            fault.short_out <= short_q; // [R13]
        end
    end

    // ==========================================================
    // Output enable and gain
    logic [1:0] ctrl;
    logic [5:0] reduction;
    logic gain_down;
    logic gain_up;
    logic signed [11:0] gain_db;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            out_en <= 1'b0;
            bias_en <= 1'b0;
        end else begin
            // Gating cuts the stage at once, no fade
            out_en <= sil_q && pdn_q && (fault == '0); // [R8] [R17]
            bias_en <= pdn_q; // [R10]
        end
    end

    aglc_limiter #(
        .RELEASE_TICKS(RELEASE_TICKS)
    ) u_limiter (
        .hclk(hclk),
        .hresetn(hresetn),
        .run(pdn_q),
        .limit_en(ctrl[aglc_pkg::CTRL_LIMIT_BIT]),
        .anticlip_en(ctrl[aglc_pkg::CTRL_CLIP_BIT]),
        .volume(vol_q),
        .peak_over(peak_q),
        .clip_seen(clip_q),
        .ideal_below(ideal_q),
        .reduction(reduction),
        .gain_down(gain_down),
        .gain_up(gain_up)
    );

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            gain_step <= '0;
            gain_db <= aglc_pkg::step_gain(6'h00);
        end else begin
            // Reductions sit under the volume ceiling
            gain_step <= (vol_q > reduction) ? vol_q - reduction : '0; // [R18]
            gain_db <= aglc_pkg::step_gain(gain_step); // [R1]
        end
    end

    // ==========================================================
    // Interrupt sources
    aglc_pkg::aglc_fault_s fault_d;
    aglc_pkg::aglc_event_s ev;
    logic [4:0] int_stat;
    logic [4:0] int_mask;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fault_d <= 3'h1;
        end else begin
            fault_d <= fault;
        end
    end

    assign ev = '{fault_otp: fault.over_temp & ~fault_d.over_temp,
        fault_short: fault.short_out & ~fault_d.short_out,
        fault_supply: fault.supply_low & ~fault_d.supply_low,
        gain_up: gain_up, gain_down: gain_down};

    // ==========================================================
    // Bus slave, zero wait states
    logic acc;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic rd_stat;

    assign acc = hsel && hready && htrans[1];
    assign rd_stat = acc && !hwrite && (haddr[7:0] == aglc_pkg::ADDR_INT_STAT)
        && (haddr[31:8] == '0);
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            wr_addr <= '0;
        end else if (hready) begin
            wr_pend <= acc && hwrite && (haddr[31:8] == '0);
            wr_addr <= haddr[7:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl <= aglc_pkg::CTRL_RESET;
            int_mask <= aglc_pkg::INT_MASK_RESET;
        end else if (wr_pend) begin
            if (wr_addr == aglc_pkg::ADDR_CTRL) begin
                ctrl <= hwdata[1:0];
            end
            if (wr_addr == aglc_pkg::ADDR_INT_MASK) begin
                int_mask <= hwdata[aglc_pkg::INT_W-1:0];
            end
        end
    end

    // A read clears what it returned; a new event in that cycle survives
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            int_stat <= '0;
        end else begin
            int_stat <= (rd_stat ? 5'h00 : int_stat) | ev;
        end
    end

    assign irq = |(int_stat & int_mask);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= '0;
        end else if (acc && !hwrite) begin
            hrdata <= '0;
            if (haddr[31:8] == '0) begin
                case (haddr[7:0])
                    aglc_pkg::ADDR_CTRL: begin
                        hrdata[1:0] <= ctrl;
                    end
                    aglc_pkg::ADDR_STATE: begin
                        hrdata[aglc_pkg::ST_VOL_LSB +: 6] <= vol_q;
                        hrdata[aglc_pkg::ST_APPLIED_LSB +: 6] <= gain_step;
                        hrdata[aglc_pkg::ST_OUT_EN_BIT] <= out_en;
                        hrdata[aglc_pkg::ST_FAULT_LSB +: 3] <= fault;
                        hrdata[aglc_pkg::ST_REDUCING_BIT] <= reduction != '0;
                    end
                    aglc_pkg::ADDR_GAIN: begin
                        hrdata <= 32'(gain_db);
                    end
                    aglc_pkg::ADDR_INT_STAT: begin
                        hrdata[aglc_pkg::INT_W-1:0] <= int_stat;
                    end
                    aglc_pkg::ADDR_INT_MASK: begin
                        hrdata[aglc_pkg::INT_W-1:0] <= int_mask;
                    end
                    default: begin
                        hrdata <= '0;
                    end
                endcase
            end
        end
    end

    // ==========================================================
    // Checks
    property p_silence_off;
        @(posedge hclk) disable iff (!hresetn)
        !sil_q |=> !out_en;
    endproperty
    a_silence_off: assert property (p_silence_off) // [R8]
        else $error("outputs on while silenced");

    property p_power_down;
        @(posedge hclk) disable iff (!hresetn)
        !pdn_q |=> !bias_en && !out_en;
    endproperty
    a_power_down: assert property (p_power_down) // [R10]
        else $error("bias or outputs on in power down");

    property p_supply_hold;
        @(posedge hclk) disable iff (!hresetn)
        fault.supply_low && !ok_q |=> fault.supply_low && !out_en;
    endproperty
    a_supply_hold: assert property (p_supply_hold) // [R12]
        else $error("left supply lockout below recovery level");

    property p_short_off;
        @(posedge hclk) disable iff (!hresetn)
        short_q |=> ##1 !out_en;
    endproperty
    a_short_off: assert property (p_short_off) // [R13]
        else $error("outputs on during short");

    property p_temp_hold;
        @(posedge hclk) disable iff (!hresetn)
        fault.over_temp && !cool_q |=> fault.over_temp;
    endproperty
    a_temp_hold: assert property (p_temp_hold) // [R14]
        else $error("thermal fault cleared before cooling");

    property p_ceiling;
        @(posedge hclk) disable iff (!hresetn)
        ##1 gain_step <= $past(vol_q);
    endproperty
    a_ceiling: assert property (p_ceiling) // [R18]
        else $error("applied gain above volume gain");

    property p_gain_table;
        @(posedge hclk) disable iff (!hresetn)
        gain_step == 6'h0a |=> gain_db == 12'sh000;
    endproperty
    a_gain_table: assert property (p_gain_table) // [R1]
        else $error("step 10 is not 0 dB");

    property p_read_clear;
        @(posedge hclk) disable iff (!hresetn)
        rd_stat && ev == '0 |=> int_stat == '0;
    endproperty
    a_read_clear: assert property (p_read_clear)
        else $error("status not cleared by read");

endmodule

// [dv/aglc_host_model.sv]
`timescale 1ns/10ps
module aglc_host_model (
    // Clock
    input wire logic hclk,
    // Host pins
    output logic silence_n,
    output logic power_down_n,
    output logic [5:0] volume_code
);
    // ==========================================================
    // Pin drive
    logic mute_drv = 1'b1;
    logic mute_val = 1'b1;
    logic pd_drv = 1'b1;
    logic pd_val = 1'b1;
    logic [5:0] vol = 6'h00;
    // A released pin follows its pull-up
    assign silence_n = mute_drv ? mute_val : 1'b1;
    assign power_down_n = pd_drv ? pd_val : 1'b1;
    assign volume_code = vol;

    task automatic set_mute(input logic drv, input logic v);
        @(posedge hclk);
        mute_drv <= drv;
        mute_val <= v;
    endtask

    task automatic set_pd(input logic drv, input logic v);
        @(posedge hclk);
        pd_drv <= drv;
        pd_val <= v;
    endtask

    task automatic set_volume(input logic [5:0] v);
        @(posedge hclk);
        vol <= v;
    endtask

    // Mute first so a supply change stays quiet
    task automatic quiet_supply();
        set_mute(1'b1, 1'b0);
        repeat (8) @(posedge hclk);
    endtask
endmodule

// [dv/tb_top.sv]
`timescale 1ns/10ps
module tb_top;
    // ==========================================================
    // Signals
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    wire logic hready;
    logic [31:0] hrdata;
    logic hreadyout, hresp, out_en, bias_en, irq;
    logic silence_n, power_down_n;
    logic [5:0] volume_code, gain_step;
    logic peak_over = 1'b0;
    logic ideal_below = 1'b0;
    logic clip_seen = 1'b0;
    logic vdd_le_1v8 = 1'b0;
    logic vdd_ge_2v0 = 1'b1;
    logic temp_hot = 1'b0;
    logic temp_cooled = 1'b0;
    logic short_seen = 1'b0;
    int n_fail = 0;
    int checked = 0;
    int cycles = 0;
    logic [31:0] rd;
    localparam logic [5:0] STEPS [6] = '{6'h00, 6'h06, 6'h0a, 6'h0c, 6'h0d,
        6'h3f};
    localparam logic [31:0] GAINS [6] = '{32'hfffffd12, 32'hffffff9c,
        32'h00000000, 32'h0000001e, 32'h00000028, 32'h000000f0};

    assign hready = hreadyout;
    always #5 hclk = ~hclk;

    aglc_host_model host (
        .hclk(hclk), .silence_n(silence_n), .power_down_n(power_down_n),
        .volume_code(volume_code));

    // Short release spacing keeps the run brief
    aglc_top #(.RELEASE_TICKS(5)) DUT (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .silence_n(silence_n), .power_down_n(power_down_n),
        .volume_code(volume_code), .peak_over(peak_over),
        .ideal_below(ideal_below), .clip_seen(clip_seen),
        .vdd_le_1v8(vdd_le_1v8), .vdd_ge_2v0(vdd_ge_2v0),
        .temp_hot(temp_hot), .temp_cooled(temp_cooled),
        .short_seen(short_seen), .out_en(out_en), .bias_en(bias_en),
        .gain_step(gain_step), .irq(irq));

    // ==========================================================
    // Helpers
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    always @(posedge hclk) begin
        cycles++;
        if (cycles == 50000) begin
            n_fail++;
            end_of_test();
        end
    end

    task automatic check(input string name, input logic [31:0] seen,
        input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s exp %h seen %h", name, exp, seen);
        end
    endtask

    task automatic bus(input logic wr, input logic [7:0] a,
        input logic [31:0] wd, output logic [31:0] q);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= wd;
        do @(posedge hclk); while (hready !== 1'b1);
        q = hrdata;
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic wait_n(input int n);
        repeat (n) @(posedge hclk);
        #1;
    endtask

    task automatic wait_gain(input logic [5:0] g, output int n);
        n = 0;
        while (gain_step !== g && n < 12000) begin
            @(posedge hclk);
            #1;
            n++;
        end
        check("gain_step", gain_step, g);
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_reset();
        bus(1'b0, aglc_pkg::ADDR_CTRL, 32'h0, rd);
        check("ctrl", rd, 32'h3);
        bus(1'b0, aglc_pkg::ADDR_INT_MASK, 32'h0, rd);
        check("mask", rd, 32'h0);
        wr_reg(8'h40, 32'hffffffff);
        bus(1'b0, 8'h40, 32'h0, rd);
        check("unmapped", rd, 32'h0);
        check("hresp", hresp, 1'b0);
        bus(1'b0, aglc_pkg::ADDR_STATE, 32'h0, rd);
        check("state", rd, 32'h00010000);
        check("out_en", out_en, 1'b1);
        $display("test reset done");
    endtask

    task automatic t_gain();
        for (int i = 0; i < 6; i++) begin
            host.set_volume(STEPS[i]);
            wait_n(12);
            check("step", gain_step, STEPS[i]);
            bus(1'b0, aglc_pkg::ADDR_GAIN, 32'h0, rd);
            check("gain", rd, GAINS[i]);
        end
        $display("test gain done");
    endtask

    task automatic t_pins();
        host.set_mute(1'b1, 1'b0);
        wait_n(8);
        check("mute", out_en, 1'b0);
        check("bias", bias_en, 1'b1);
        host.set_mute(1'b0, 1'b0);
        wait_n(8);
        check("float mute", out_en, 1'b1);
        host.set_pd(1'b1, 1'b0);
        wait_n(8);
        check("pd bias", bias_en, 1'b0);
        check("pd out", out_en, 1'b0);
        host.set_pd(1'b0, 1'b0);
        wait_n(8);
        check("float pd", bias_en, 1'b1);
        check("float pd out", out_en, 1'b1);
        $display("test pins done");
    endtask

    task automatic t_faults();
        bus(1'b0, aglc_pkg::ADDR_INT_STAT, 32'h0, rd);
        @(posedge hclk) short_seen <= 1'b1;
        wait_n(8);
        check("short", out_en, 1'b0);
        @(posedge hclk) short_seen <= 1'b0;
        wait_n(8);
        check("short gone", out_en, 1'b1);
        bus(1'b0, aglc_pkg::ADDR_INT_STAT, 32'h0, rd);
        check("short event", rd & 32'h8, 32'h8);
        @(posedge hclk) temp_hot <= 1'b1;
        wait_n(8);
        check("hot", out_en, 1'b0);
        @(posedge hclk) temp_hot <= 1'b0;
        wait_n(8);
        check("still hot", out_en, 1'b0);
        @(posedge hclk) temp_cooled <= 1'b1;
        wait_n(8);
        check("cooled", out_en, 1'b1);
        @(posedge hclk) temp_cooled <= 1'b0;
        host.quiet_supply();
        @(posedge hclk) vdd_le_1v8 <= 1'b1;
        @(posedge hclk) vdd_ge_2v0 <= 1'b0;
        host.set_mute(1'b1, 1'b1);
        wait_n(8);
        check("supply low", out_en, 1'b0);
        @(posedge hclk) vdd_le_1v8 <= 1'b0;
        wait_n(8);
        check("supply between", out_en, 1'b0);
        @(posedge hclk) vdd_ge_2v0 <= 1'b1;
        wait_n(8);
        check("supply ok", out_en, 1'b1);
        $display("test faults done");
    endtask

    task automatic t_limiter();
        int n;
        int bad;
        host.set_volume(6'h14);
        wr_reg(aglc_pkg::ADDR_INT_MASK, 32'h1);
        wait_n(12);
        bus(1'b0, aglc_pkg::ADDR_INT_STAT, 32'h0, rd);
        check("irq idle", irq, 1'b0);
        @(posedge hclk) peak_over <= 1'b1;
        wait_gain(6'h13, n);
        check("first drop", n < 12, 1'b1);
        wait_n(3);
        check("irq set", irq, 1'b1);
        bus(1'b0, aglc_pkg::ADDR_INT_STAT, 32'h0, rd);
        check("down event", rd & 32'h1, 32'h1);
        wait_n(1);
        check("irq clear", irq, 1'b0);
        wait_gain(6'h12, n);
        check("attack gap", n >= 3190 && n <= 3210, 1'b1);
        @(posedge hclk) peak_over <= 1'b0;
        wait_n(4000);
        check("held", gain_step, 6'h12);
        bus(1'b0, aglc_pkg::ADDR_INT_STAT, 32'h0, rd);
        @(posedge hclk) ideal_below <= 1'b1;
        wait_gain(6'h13, n);
        check("first rise", n < 12, 1'b1);
        wait_gain(6'h14, n);
        check("release gap", n >= 495 && n <= 520, 1'b1);
        bad = 0;
        repeat (1000) begin
            @(posedge hclk);
            if (gain_step > 6'h14) bad++;
        end
        check("ceiling", bad, 0);
        check("masked up", irq, 1'b0);
        @(posedge hclk) ideal_below <= 1'b0;
        $display("test limiter done");
    endtask

    task automatic t_clip();
        int n;
        wr_reg(aglc_pkg::ADDR_CTRL, 32'h2);
        host.set_volume(6'h03);
        @(posedge hclk) peak_over <= 1'b1;
        wait_n(200);
        check("limit off", gain_step, 6'h03);
        @(posedge hclk) clip_seen <= 1'b1;
        wait_gain(6'h00, n);
        check("clip steps", n >= 6400 && n <= 6500, 1'b1);
        bus(1'b0, aglc_pkg::ADDR_GAIN, 32'h0, rd);
        check("bottom", rd, 32'hfffffd12);
        @(posedge hclk) clip_seen <= 1'b0;
        @(posedge hclk) peak_over <= 1'b0;
        @(posedge hclk) ideal_below <= 1'b1;
        wait_gain(6'h03, n);
        check("clip release", n >= 990 && n <= 1040, 1'b1);
        $display("test clip done");
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        wait_n(3);
        check("reset out", out_en, 1'b0);
        check("reset irq", irq, 1'b0);
        @(posedge hclk) hresetn <= 1'b1;
        wait_n(12);
        t_reset();
        t_gain();
        t_pins();
        t_faults();
        t_limiter();
        t_clip();
        end_of_test();
    end
endmodule
